// *** common/tbg_regs.vh ***
`ifndef TBG_REGS_VH
`define TBG_REGS_VH
// register byte addresses
`define TBG_ADDR_CTRL 8'h00
`define TBG_ADDR_MODE 8'h04
`define TBG_ADDR_CNT_LO 8'h08
`define TBG_ADDR_CNT_HI 8'h0c
`define TBG_ADDR_RLD_LO 8'h10
`define TBG_ADDR_RLD_HI 8'h14
`define TBG_ADDR_IRQ_STAT 8'h18
`define TBG_ADDR_IRQ_MASK 8'h1c
// control register fields
`define TBG_CTRL_CAP_RLD 0
`define TBG_CTRL_CNT_SRC 1
`define TBG_CTRL_RUN 2
`define TBG_CTRL_EXT_EN 3
`define TBG_CTRL_TX_SEL 4
`define TBG_CTRL_RX_SEL 5
`define TBG_CTRL_EXT_FLAG 6
`define TBG_CTRL_OVF_FLAG 7
// mode register fields
`define TBG_MODE_DOWN_EN 0
`define TBG_MODE_OUT_EN 1
`define TBG_MODE_SIX_CLK 2
// irq status fields
`define TBG_IRQ_OVF 0
`define TBG_IRQ_EXT 1
// reset values
`define TBG_CTRL_RST 8'h00
`define TBG_MODE_RST 8'h00
`define TBG_CNT_RST 16'h0000
`define TBG_IRQ_RST 2'h0
// timing: machine cycle divisors, baud divider
`define TBG_DIV_SIX 4'h6
`define TBG_DIV_TWELVE 4'hc
`define TBG_DIV_BAUD_12 4'h2
`define TBG_DIV_BAUD_6 4'h1
`define TBG_BAUD_OVF_DIV 4'hf
`endif

// *** hw/tbg_edge.v ***
`timescale 1ns/1ps
// ****************************************
// falling edge detector for a sync input
// ****************************************
module tbg_edge (
  input wire clk_i,
  input wire rst_i,
  input wire pin_i,
  output wire fall_o
);
  reg last_q;
  // remember previous pin level
  always @(posedge clk_i) begin
    if (rst_i) begin
      last_q <= 1'b1;
    end else begin
      last_q <= pin_i;
    end
  end
  assign fall_o = last_q & ~pin_i;
endmodule

// *** hw/tbg_div.v ***
`timescale 1ns/1ps
// ****************************************
// programmable tick divider
// ****************************************
module tbg_div (
  input wire clk_i,
  input wire rst_i,
  input wire [3:0] div_i,
  output wire tick_o
);
  reg [3:0] cnt_q;
  wire [3:0] cnt_d;
  assign tick_o = (cnt_q + 4'h1 >= div_i);
  assign cnt_d = tick_o ? 4'h0 : cnt_q + 4'h1;
  // count oscillator cycles up to the divisor
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// *** hw/tbg_timer.v ***
// The Wishbone interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`include "tbg_regs.vh"
// Function
// - mode from run, clock selects and capture/reload select; off when not running
// - transmit clock from first timer when tx select low, else this overflow
// - receive clock chosen the same way by its own select bit
// - baud mode reloads counter from reload bytes on every rollover
// - serial bit clock equals overflow rate divided by 16
// - count source select: internal ticks when 0, external events when 1
// - timer operation outside baud mode counts once per 6 or 12 clocks
// - baud mode timer counts every clock in 6-clock, every second in 12-clock
// - bit rate is osc over n times 65536 minus reload value
// - baud mode rollover sets no overflow flag and no interrupt
// - baud mode trigger falling edge sets external flag, never reloads
module tbg_timer (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire ext_trigger_pin_i,
  input wire ext_count_pin_i,
  input wire first_timer_tx_clk_i,
  input wire first_timer_rx_clk_i,
  output wire tx_baud_clk_o,
  output wire rx_baud_clk_o,
  output reg timer_out_o,
  output wire irq_o
);
  // ****************************************
  // state
  // ****************************************
  localparam ST_OFF = 4'b0001;
  localparam ST_RELOAD = 4'b0010;
  localparam ST_CAPTURE = 4'b0100;
  localparam ST_BAUD = 4'b1000;

  reg [7:0] ctrl_q;
  reg [7:0] mode_q;
  reg [15:0] cnt_q;
  reg [15:0] rld_q;
  reg [1:0] irq_stat_q;
  reg [1:0] irq_mask_q;
  reg [3:0] baud_div_q;
  reg baud_pulse_q;
  reg [3:0] state;
  reg [3:0] div_sel;
  reg [15:0] cnt_d;
  reg cnt_ovf;
  reg cnt_step;
  wire trig_fall;
  wire ext_fall;
  wire osc_tick;
  wire wr_en;
  wire rd_en;
  wire second_timer_run;
  wire capture_reload_sel;
  wire count_source_sel;
  wire ext_trigger_enable;
  wire tx_baud_source_sel;
  wire rx_baud_source_sel;
  wire down_count_enable;
  wire timer_output_enable;
  wire six_clock_mode;

  assign capture_reload_sel = ctrl_q[`TBG_CTRL_CAP_RLD];
  assign count_source_sel = ctrl_q[`TBG_CTRL_CNT_SRC];
  assign second_timer_run = ctrl_q[`TBG_CTRL_RUN];
  assign ext_trigger_enable = ctrl_q[`TBG_CTRL_EXT_EN];
  assign tx_baud_source_sel = ctrl_q[`TBG_CTRL_TX_SEL];
  assign rx_baud_source_sel = ctrl_q[`TBG_CTRL_RX_SEL];
  assign down_count_enable = mode_q[`TBG_MODE_DOWN_EN];
  assign timer_output_enable = mode_q[`TBG_MODE_OUT_EN];
  assign six_clock_mode = mode_q[`TBG_MODE_SIX_CLK];

  // byte select helper for lane 0
  function lane_write;
    input [7:0] adr;
    input [7:0] target;
    input [3:0] sel;
    begin
      lane_write = (adr == target) & sel[0];
    end
  endfunction

  // ****************************************
  // mode decode
  // ****************************************
  // baud mode wins over capture/reload whenever either clock select is set
  always @* begin
    if (!second_timer_run) begin
      state = ST_OFF;
    end else if (tx_baud_source_sel | rx_baud_source_sel) begin
      state = ST_BAUD;
    end else if (capture_reload_sel) begin
      state = ST_CAPTURE;
    end else begin
      state = ST_RELOAD;
    end
  end

  // ****************************************
  // count tick generation
  // ****************************************
  // the divisor follows the mode at once; a change keeps the running phase
  always @* begin
    case (state)
      ST_BAUD: div_sel = six_clock_mode ? `TBG_DIV_BAUD_6 : `TBG_DIV_BAUD_12;
      default: div_sel = six_clock_mode ? `TBG_DIV_SIX : `TBG_DIV_TWELVE;
    endcase
  end

  tbg_div u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .div_i(div_sel),
    .tick_o(osc_tick)
  );

  tbg_edge u_trig_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(ext_trigger_pin_i),
    .fall_o(trig_fall)
  );

  tbg_edge u_cnt_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(ext_count_pin_i),
    .fall_o(ext_fall)
  );

  // ****************************************
  // counter next value
  // ****************************************
  // with down count enabled in auto-reload the trigger pin sets direction: high up, low down
  always @* begin
    cnt_step = (state != ST_OFF) & (count_source_sel ? ext_fall : osc_tick);
    cnt_d = cnt_q;
    cnt_ovf = 1'b0;
    if (cnt_step) begin
      if (state == ST_RELOAD && down_count_enable && !ext_trigger_pin_i) begin
        // down count: underflow at reload value wraps to all ones
        if (cnt_q == rld_q) begin
          cnt_d = 16'hffff;
          cnt_ovf = 1'b1;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end else if (cnt_q == 16'hffff) begin
        cnt_ovf = 1'b1;
        cnt_d = (state == ST_CAPTURE) ? 16'h0000 : rld_q;
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
  end

  // a request is taken only while ack is low, so one access never acts twice
  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign rd_en = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;

  // ****************************************
  // registers, flags and counter
  // ****************************************
  // the count step lands first, then software writes override it, then hardware events override both
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `TBG_CTRL_RST;
      mode_q <= `TBG_MODE_RST;
      cnt_q <= `TBG_CNT_RST;
      rld_q <= `TBG_CNT_RST;
      timer_out_o <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      if (wr_en && lane_write(wb_adr_i, `TBG_ADDR_CTRL, wb_sel_i)) begin
        ctrl_q <= wb_dat_i[7:0];
      end
      if (wr_en && lane_write(wb_adr_i, `TBG_ADDR_MODE, wb_sel_i)) begin
        mode_q <= {5'h00, wb_dat_i[2:0]};
      end
      if (wr_en && lane_write(wb_adr_i, `TBG_ADDR_CNT_LO, wb_sel_i)) begin
        cnt_q[7:0] <= wb_dat_i[7:0];
      end
      if (wr_en && lane_write(wb_adr_i, `TBG_ADDR_CNT_HI, wb_sel_i)) begin
        cnt_q[15:8] <= wb_dat_i[7:0];
      end
      if (wr_en && lane_write(wb_adr_i, `TBG_ADDR_RLD_LO, wb_sel_i)) begin
        rld_q[7:0] <= wb_dat_i[7:0];
      end
      if (wr_en && lane_write(wb_adr_i, `TBG_ADDR_RLD_HI, wb_sel_i)) begin
        rld_q[15:8] <= wb_dat_i[7:0];
      end
      // hardware events win over a software write of the flags
      if (cnt_ovf && state != ST_BAUD) begin
        ctrl_q[`TBG_CTRL_OVF_FLAG] <= 1'b1;
      end
      if (trig_fall && ext_trigger_enable && state != ST_OFF) begin
        ctrl_q[`TBG_CTRL_EXT_FLAG] <= 1'b1;
      end
      // capture copies the running count into the reload bytes
      if (trig_fall && ext_trigger_enable && state == ST_CAPTURE) begin
        rld_q <= cnt_q;
      end
      // reload on trigger in auto-reload mode with down count disabled only, never in baud mode
      if (trig_fall && ext_trigger_enable && state == ST_RELOAD && !down_count_enable) begin
        cnt_q <= rld_q;
      end
      if (cnt_ovf && timer_output_enable) begin
        timer_out_o <= ~timer_out_o;
      end
    end
  end

  // ****************************************
  // baud output: overflow divided by 16
  // ****************************************
  // the prescaler is not cleared on entering baud mode, so the first bit clock may come early
  always @(posedge clk_i) begin
    if (rst_i) begin
      baud_div_q <= 4'h0;
      baud_pulse_q <= 1'b0;
    end else begin
      baud_pulse_q <= 1'b0;
      if (cnt_ovf && state == ST_BAUD) begin
        baud_div_q <= baud_div_q + 4'h1;
        baud_pulse_q <= (baud_div_q == `TBG_BAUD_OVF_DIV);
      end
    end
  end

  assign tx_baud_clk_o = tx_baud_source_sel ? baud_pulse_q : first_timer_tx_clk_i;
  assign rx_baud_clk_o = rx_baud_source_sel ? baud_pulse_q : first_timer_rx_clk_i;

  // ****************************************
  // interrupt status and mask
  // ****************************************
  // a read clears the status, but an event in the same cycle is kept
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= `TBG_IRQ_RST;
      irq_mask_q <= `TBG_IRQ_RST;
    end else begin
      if (rd_en && wb_adr_i == `TBG_ADDR_IRQ_STAT) begin
        irq_stat_q <= `TBG_IRQ_RST;
      end
      if (cnt_ovf && state != ST_BAUD) begin
        irq_stat_q[`TBG_IRQ_OVF] <= 1'b1;
      end
      if (trig_fall && ext_trigger_enable && state != ST_OFF) begin
        irq_stat_q[`TBG_IRQ_EXT] <= 1'b1;
      end
      if (wr_en && lane_write(wb_adr_i, `TBG_ADDR_IRQ_MASK, wb_sel_i)) begin
        irq_mask_q <= wb_dat_i[1:0];
      end
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);

  // ****************************************
  // wishbone answer and read data
  // ****************************************
  // ack comes one cycle after the request is taken; read data holds until the next read
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (rd_en) begin
        if (wb_adr_i == `TBG_ADDR_CTRL) begin
          wb_dat_o <= {24'h000000, ctrl_q};
        end else if (wb_adr_i == `TBG_ADDR_MODE) begin
          wb_dat_o <= {24'h000000, mode_q};
        end else if (wb_adr_i == `TBG_ADDR_CNT_LO) begin
          wb_dat_o <= {24'h000000, cnt_q[7:0]};
        end else if (wb_adr_i == `TBG_ADDR_CNT_HI) begin
          wb_dat_o <= {24'h000000, cnt_q[15:8]};
        end else if (wb_adr_i == `TBG_ADDR_RLD_LO) begin
          wb_dat_o <= {24'h000000, rld_q[7:0]};
        end else if (wb_adr_i == `TBG_ADDR_RLD_HI) begin
          wb_dat_o <= {24'h000000, rld_q[15:8]};
        end else if (wb_adr_i == `TBG_ADDR_IRQ_STAT) begin
          wb_dat_o <= {30'h00000000, irq_stat_q};
        end else if (wb_adr_i == `TBG_ADDR_IRQ_MASK) begin
          wb_dat_o <= {30'h00000000, irq_mask_q};
        end else begin
          wb_dat_o <= 32'h00000000; // unmapped reads zero
        end
      end
    end
  end
endmodule

// *** test/tbg_serial_model.sv ***
`timescale 1ns/1ps
// ***
// serial port side: first timer clocks, bit clock spacing
// ***
module tbg_serial_model (
  input wire clk_i,
  input wire tx_i,
  input wire rx_i,
  output wire ft_tx_o,
  output wire ft_rx_o,
  output reg [15:0] tx_gap_o = 16'h0,
  output reg [15:0] rx_gap_o = 16'h0
);
  reg [3:0] div_q = 4'h0;
  reg [15:0] tx_cnt_q = 16'h0;
  reg [15:0] rx_cnt_q = 16'h0;
  assign ft_tx_o = div_q[1];
  assign ft_rx_o = div_q[2];
  // first timer clocks run free; spacing counted pulse to pulse
  always @(posedge clk_i) begin
    div_q <= div_q + 4'h1;
    tx_cnt_q <= tx_i ? 16'h1 : tx_cnt_q + 16'h1;
    rx_cnt_q <= rx_i ? 16'h1 : rx_cnt_q + 16'h1;
    if (tx_i) tx_gap_o <= tx_cnt_q;
    if (rx_i) rx_gap_o <= rx_cnt_q;
  end
endmodule

// *** test/tbg_timer_sva.sv ***
`timescale 1ns/1ps
`include "tbg_regs.vh"
// ***
// port checker
// ***
module tbg_timer_chk (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire first_timer_tx_clk_i,
  input wire first_timer_rx_clk_i,
  input wire tx_baud_clk_o,
  input wire rx_baud_clk_o,
  input wire timer_out_o,
  input wire irq_o
);
  reg tx_sel_q = 1'b0;
  reg rx_sel_q = 1'b0;
  reg [1:0] mask_q = 2'h0;
  wire wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
  // shadow of select and mask bits
  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_sel_q <= 1'b0;
      rx_sel_q <= 1'b0;
      mask_q <= 2'h0;
    end else if (wr && wb_adr_i == `TBG_ADDR_CTRL) begin
      tx_sel_q <= wb_dat_i[`TBG_CTRL_TX_SEL];
      rx_sel_q <= wb_dat_i[`TBG_CTRL_RX_SEL];
    end else if (wr && wb_adr_i == `TBG_ADDR_IRQ_MASK) begin
      mask_q <= wb_dat_i[1:0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_txp; tx_sel_q && tx_baud_clk_o; endsequence
  property p_ack; s_req |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  property p_unmap; s_req ##0 (!wb_we_i && wb_adr_i > 8'h1c) |=> wb_dat_o == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_tx_src; !tx_sel_q |-> tx_baud_clk_o == first_timer_tx_clk_i; endproperty
  a_tx_src: assert property (p_tx_src) else $error("tx source");
  property p_rx_src; !rx_sel_q |-> rx_baud_clk_o == first_timer_rx_clk_i; endproperty
  a_rx_src: assert property (p_rx_src) else $error("rx source");
  property p_tx_pulse; s_txp ##1 tx_sel_q |-> !tx_baud_clk_o; endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("tx pulse");
  property p_mask; mask_q == 2'h0 |-> !irq_o; endproperty
  a_mask: assert property (p_mask) else $error("masked irq");
  property p_rst; $fell(rst_i) |-> !wb_ack_o && !irq_o && !timer_out_o; endproperty
  a_rst: assert property (p_rst) else $error("reset outputs");
endmodule
bind tbg_timer tbg_timer_chk chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .first_timer_tx_clk_i, .first_timer_rx_clk_i, .tx_baud_clk_o,
  .rx_baud_clk_o, .timer_out_o, .irq_o);

// *** test/testbench.sv ***
`timescale 1ns/1ps
`include "tbg_regs.vh"
// ***
// bus master, pins and checks
// ***
module testbench;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg cyc = 1'b0;
  reg we = 1'b0;
  reg [7:0] adr = 8'h00;
  reg [7:0] dat = 8'h00;
  reg trig = 1'b1;
  reg ecnt = 1'b1;
  wire [31:0] dat_o;
  wire ack, tx, rx, ft_tx, ft_rx, irq, tout;
  wire [15:0] tx_gap, rx_gap;
  reg [15:0] rd;
  reg [15:0] r;
  reg six;
  reg [1:0] bs;
  integer i, miscompares = 0, comparisons = 0, cycles = 0;
  tbg_timer dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i({24'h0, dat}), .wb_dat_o(dat_o), .wb_ack_o(ack), .ext_trigger_pin_i(trig),
    .ext_count_pin_i(ecnt), .first_timer_tx_clk_i(ft_tx), .first_timer_rx_clk_i(ft_rx), .tx_baud_clk_o(tx),
    .rx_baud_clk_o(rx), .timer_out_o(tout), .irq_o(irq));
  tbg_serial_model link_u (.clk_i(clk_i), .tx_i(tx), .rx_i(rx), .ft_tx_o(ft_tx), .ft_rx_o(ft_rx),
    .tx_gap_o(tx_gap), .rx_gap_o(rx_gap));
  // clock
  initial forever #20 clk_i = ~clk_i;
  task wrap_up;
    if (miscompares == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input [15:0] seen, input [15:0] exp, input string what);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("[FAIL] %0s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one classic cycle, held until ack
  task wb(input w, input [7:0] a, input [7:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rd = dat_o[15:0];
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  // falling edges on the trigger or count pin
  task pulse(input integer n, input pin);
    repeat (n) begin
      if (pin) ecnt <= 1'b0;
      else trig <= 1'b0;
      repeat (4) @(posedge clk_i);
      if (pin) ecnt <= 1'b1;
      else trig <= 1'b1;
      repeat (4) @(posedge clk_i);
    end
  endtask
  function [15:0] gap(input s, input [15:0] v);
    gap = 16'((s ? 16 : 32) * (65536 - v));
  endfunction
  // cut a hang short
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares = miscompares + 1;
      wrap_up;
    end
  end
  initial begin
    void'($urandom(23));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (i = 0; i < 9; i = i + 1) begin
      wb(1'b0, 8'(i * 4), 8'h00);
      chk(rd, 16'h0000, "reset or unmapped read");
    end
    wb(1'b1, `TBG_ADDR_CNT_HI, 8'hff);
    repeat (4) begin
      r = 16'hfff0 + 16'($urandom_range(14));
      six = 1'($urandom_range(1));
      bs = 2'($urandom_range(3, 1));
      wb(1'b1, `TBG_ADDR_RLD_LO, r[7:0]);
      wb(1'b1, `TBG_ADDR_RLD_HI, r[15:8]);
      wb(1'b1, `TBG_ADDR_MODE, {5'h0, six, 2'h0});
      wb(1'b1, `TBG_ADDR_CTRL, {2'h0, bs, 4'h4});
      repeat (2000) @(posedge clk_i);
      if (bs[0]) chk(tx_gap, gap(six, r), "tx spacing");
      if (bs[1]) chk(rx_gap, gap(six, r), "rx spacing");
      wb(1'b0, `TBG_ADDR_CTRL, 8'h00);
      chk(rd & 16'h0080, 16'h0000, "baud overflow flag");
    end
    wb(1'b1, `TBG_ADDR_MODE, 8'h00);
    wb(1'b1, `TBG_ADDR_RLD_LO, 8'h00);
    wb(1'b1, `TBG_ADDR_RLD_HI, 8'h00);
    wb(1'b1, `TBG_ADDR_CNT_LO, 8'h00);
    wb(1'b1, `TBG_ADDR_CNT_HI, 8'h10);
    wb(1'b1, `TBG_ADDR_CTRL, 8'h1c);
    for (i = 0; i < 2; i = i + 1) begin
      wb(1'b1, `TBG_ADDR_IRQ_MASK, i ? 8'h00 : 8'h02);
      pulse(1, 1'b0);
      chk({15'h0, irq}, i ? 16'h0 : 16'h1, "irq level");
      wb(1'b0, `TBG_ADDR_IRQ_STAT, 8'h00);
      chk(rd, 16'h0002, "irq status");
      chk({15'h0, irq}, 16'h0000, "irq after read");
    end
    wb(1'b0, `TBG_ADDR_CNT_HI, 8'h00);
    chk(rd, 16'h0010, "no reload on trigger");
    wb(1'b0, `TBG_ADDR_CTRL, 8'h00);
    chk(rd & 16'h0040, 16'h0040, "trigger flag");
    wb(1'b1, `TBG_ADDR_CTRL, 8'h00);
    wb(1'b1, `TBG_ADDR_RLD_HI, 8'hff);
    wb(1'b1, `TBG_ADDR_RLD_LO, 8'hf0);
    wb(1'b1, `TBG_ADDR_CNT_LO, 8'hf0);
    wb(1'b1, `TBG_ADDR_CNT_HI, 8'hff);
    wb(1'b1, `TBG_ADDR_MODE, 8'h02);
    wb(1'b1, `TBG_ADDR_CTRL, 8'h04);
    repeat (150) @(posedge clk_i);
    wb(1'b0, `TBG_ADDR_CTRL, 8'h00);
    chk(rd & 16'h0080, 16'h0000, "overflow too early");
    repeat (110) @(posedge clk_i);
    chk({15'h0, tout}, 16'h0001, "timer output toggle");
    wb(1'b0, `TBG_ADDR_CTRL, 8'h00);
    chk(rd & 16'h0080, 16'h0080, "overflow flag");
    wb(1'b0, `TBG_ADDR_CNT_HI, 8'h00);
    chk(rd, 16'h00ff, "reloaded high byte");
    wb(1'b0, `TBG_ADDR_IRQ_STAT, 8'h00);
    chk(rd, 16'h0001, "overflow status");
    wb(1'b1, `TBG_ADDR_CTRL, 8'h00);
    wb(1'b1, `TBG_ADDR_CNT_LO, 8'h00);
    wb(1'b1, `TBG_ADDR_CNT_HI, 8'h5a);
    wb(1'b1, `TBG_ADDR_CTRL, 8'h0d);
    pulse(1, 1'b0);
    wb(1'b0, `TBG_ADDR_RLD_HI, 8'h00);
    chk(rd, 16'h005a, "captured high byte");
    wb(1'b1, `TBG_ADDR_CTRL, 8'h00);
    wb(1'b1, `TBG_ADDR_CNT_LO, 8'h00);
    for (i = 0; i < 2; i = i + 1) begin
      wb(1'b1, `TBG_ADDR_CTRL, i ? 8'h02 : 8'h06);
      pulse(5, 1'b1);
      wb(1'b0, `TBG_ADDR_CNT_LO, 8'h00);
      chk(rd, 16'h0005, "event count");
    end
    wb(1'b1, `TBG_ADDR_MODE, 8'h01);
    wb(1'b1, `TBG_ADDR_CTRL, 8'h06);
    trig <= 1'b0;
    pulse(3, 1'b1);
    wb(1'b0, `TBG_ADDR_CNT_LO, 8'h00);
    chk(rd, 16'h0002, "down count");
    wb(1'b1, `TBG_ADDR_MODE, 8'h00);
    pulse(1, 1'b1);
    wb(1'b0, `TBG_ADDR_CNT_LO, 8'h00);
    chk(rd, 16'h0003, "up only without down enable");
    wrap_up;
  end
endmodule
